// ===== pkg/gos_pkg.sv
// Purpose: shared constants and carriers for the line-mode colour select and power-down bank
// Assumes: 6-bit register address, 8-bit register data, one clock (mclk)
// Notes: offsets are register addresses on the plain register port
package gos_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // register addresses
  localparam logic [5:0] OFS_CYCLE_RESTART = 6'h05;
  localparam logic [5:0] OFS_LINE_MODE = 6'h06;
  localparam logic [5:0] OFS_POWER = 6'h07;
  localparam logic [5:0] OFS_CLAMP_CFG = 6'h0a;
  localparam logic [5:0] OFS_STATUS = 6'h0b;

  // line_mode_setup fields
  localparam int LM_SINGLE_LINE_BIT = 0;
  localparam int LM_AUTO_CYCLE_BIT = 1;
  localparam int LM_MANUAL_LO = 2;
  localparam int LM_MANUAL_HI = 3;
  localparam logic [7:0] LINE_MODE_RST = 8'h00;

  // path_power_down fields
  localparam int PD_RED_BIT = 0;
  localparam int PD_GREEN_BIT = 1;
  localparam int PD_BLUE_BIT = 2;
  localparam int PD_CONVERTER_BIT = 3;
  localparam int PD_CLAMP_DAC_BIT = 4;
  localparam int PD_USED_W = 5;
  localparam logic [4:0] POWER_RST = 5'h00;

  // clamp_setup fields
  localparam int CC_CLAMP_OVR_BIT = 0;
  localparam int CC_CDS_BIT = 1;
  localparam logic [1:0] CLAMP_CFG_RST = 2'h0;

  // status fields
  localparam int ST_SLOT_LO = 0;
  localparam int ST_SEL_LO = 2;
  localparam int ST_AUTO_BIT = 4;
  localparam int ST_CONFLICT_BIT = 5;

  // colour select codes
  localparam logic [1:0] SEL_RED = 2'h0;
  localparam logic [1:0] SEL_GREEN = 2'h1;
  localparam logic [1:0] SEL_BLUE = 2'h2;
  localparam logic [1:0] SEL_RSVD = 2'h3;

  typedef enum logic [1:0] {gos_slot_red, gos_slot_green, gos_slot_blue} gos_slot_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } gos_bus_t;

  typedef struct packed {
    logic clamp_dac;
    logic converter;
    logic blue;
    logic green;
    logic red;
  } gos_power_t;

  typedef struct packed {
    logic clamp_close;
    logic cds_en;
    logic [1:0] colour_sel;
  } gos_front_t;
endpackage

// ===== verilog/gos_sync.sv
// Purpose: two-flop synchroniser for a pin level
// Assumes: synchronous active-low reset
// Notes: only the second flop is visible outside
`timescale 1ns/1ps
module gos_sync (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pin_in,
  output logic pin_sync
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign pin_sync = sync_ff;
endmodule // gos_sync

// ===== verilog/gos_top.sv
// Purpose: line-mode colour select, auto-cycling and path power-down bank
// Assumes: reset_sample_pin is asynchronous to mclk; registers on a plain port
// Notes: read data stand only in the cycle after the read strobe
// Functional notes
// - auto-cycling off: pin drives clamp, manual field selects gain/offset in line-by-line mode
// - auto-cycling on: each pin pulse advances to next gain/offset set
// - cycle order red, green, blue, back to red on the red input
// - auto-cycling on: clamp follows override bit, not the pin
// - manual field ignored when line mode off or auto-cycling on
// - manual codes 00/01/10 select red/green/blue; 11 reserved
// - power bit 0 powers down the red path
// - power bit 1 powers down the green path
// - power bit 2 powers down the blue path
// - power bit 3 powers down converter only, references stay up
// - power bit 4 powers down clamp DAC and floats its output
// - line-mode bit 0: 0 normal, 1 line-by-line, default 0
// - auto-cycle bit only acts in line-by-line mode
// - any write to the restart address returns the cycle to red
`timescale 1ns/1ps
module gos_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire gos_pkg::gos_bus_t bus,
  output logic [7:0] rdata,
  input wire logic reset_sample_pin,
  output gos_pkg::gos_power_t power,
  output gos_pkg::gos_front_t front,
  output logic clamp_dac_oe
);
  import gos_pkg::*;

  logic [7:0] line_mode_ff;
  logic [4:0] power_reg_ff;
  logic [1:0] clamp_cfg_ff;
  logic [7:0] rdata_ff;
  gos_slot_t slot_ff;
  gos_slot_t nxt_slot;
  gos_power_t power_ff;
  gos_power_t nxt_power;
  gos_front_t front_ff;
  gos_front_t nxt_front;
  logic reset_sample_pin_sync;
  logic reset_sample_pin_prev_ff;
  logic reset_sample_pin_pulse;
  logic single_line_mode;
  logic auto_cycle_enable;
  logic auto_active;
  logic [1:0] manual_colour_select;
  logic clamp_override;
  logic correlated_sampling_enable;
  logic restart_wr;
  logic [2:0] colour_pd_reg;
  logic [2:0] colour_pd_out;

  function automatic logic hit(input gos_bus_t b, input logic [5:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction

  function automatic gos_slot_t slot_after(input gos_slot_t s);
    unique case (s)
      gos_slot_red: slot_after = gos_slot_green;
      gos_slot_green: slot_after = gos_slot_blue;
      gos_slot_blue: slot_after = gos_slot_red;
      default: slot_after = gos_slot_red;
    endcase
  endfunction

  function automatic logic [1:0] slot_code(input gos_slot_t s);
    unique case (s)
      gos_slot_red: slot_code = SEL_RED;
      gos_slot_green: slot_code = SEL_GREEN;
      gos_slot_blue: slot_code = SEL_BLUE;
      default: slot_code = SEL_RED;
    endcase
  endfunction

  // pin crosses into mclk before anything looks at it
  gos_sync u_reset_sample_pin_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin_in(reset_sample_pin),
    .pin_sync(reset_sample_pin_sync)
  );

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reset_sample_pin_prev_ff <= 1'b0;
    end else begin
      reset_sample_pin_prev_ff <= reset_sample_pin_sync;
    end
  end

  // rising edge marks one pulse
  assign reset_sample_pin_pulse = reset_sample_pin_sync && !reset_sample_pin_prev_ff;

  assign single_line_mode = line_mode_ff[LM_SINGLE_LINE_BIT];
  assign auto_cycle_enable = line_mode_ff[LM_AUTO_CYCLE_BIT];
  assign manual_colour_select = line_mode_ff[LM_MANUAL_HI:LM_MANUAL_LO];
  assign auto_active = single_line_mode && auto_cycle_enable;
  assign clamp_override = clamp_cfg_ff[CC_CLAMP_OVR_BIT];
  assign correlated_sampling_enable = clamp_cfg_ff[CC_CDS_BIT];
  assign restart_wr = hit(bus, OFS_CYCLE_RESTART);

  // register writes; upper line-mode bits are stored as written
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      line_mode_ff <= LINE_MODE_RST;
    end else if (hit(bus, OFS_LINE_MODE)) begin
      line_mode_ff <= bus.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      power_reg_ff <= POWER_RST;
    end else if (hit(bus, OFS_POWER)) begin
      power_reg_ff <= bus.wdata[PD_USED_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clamp_cfg_ff <= CLAMP_CFG_RST;
    end else if (hit(bus, OFS_CLAMP_CFG)) begin
      clamp_cfg_ff <= bus.wdata[1:0];
    end
  end

  // auto-cycle counter; a restart write beats a pulse in the same cycle
  always_comb begin
    nxt_slot = slot_ff;
    if (restart_wr) begin
      nxt_slot = gos_slot_red;
    end else if (auto_active && reset_sample_pin_pulse) begin
      nxt_slot = slot_after(slot_ff);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      slot_ff <= gos_slot_red;
    end else begin
      slot_ff <= nxt_slot;
    end
  end

  // front-end controls
  always_comb begin
    nxt_front = front_ff;
    nxt_front.cds_en = correlated_sampling_enable;
    if (!single_line_mode) begin
      nxt_front.colour_sel = SEL_RED;
      nxt_front.clamp_close = reset_sample_pin_sync;
    end else if (auto_active) begin
      nxt_front.colour_sel = slot_code(slot_ff);
      nxt_front.clamp_close = clamp_override;
    end else begin
      // reserved code keeps the previous selection rather than guessing
      if (manual_colour_select != SEL_RSVD) begin
        nxt_front.colour_sel = manual_colour_select;
      end
      nxt_front.clamp_close = reset_sample_pin_sync;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      front_ff <= '0;
    end else begin
      front_ff <= nxt_front;
    end
  end

  // green and blue amplifiers sit idle in line mode, so they are forced down
  assign colour_pd_reg = power_reg_ff[PD_BLUE_BIT:PD_RED_BIT];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_colour_pd
      if (gi == PD_RED_BIT) begin : g_red
        assign colour_pd_out[gi] = colour_pd_reg[gi];
      end else begin : g_other
        assign colour_pd_out[gi] = colour_pd_reg[gi] || single_line_mode;
      end
    end
  endgenerate

  always_comb begin
    nxt_power.red = colour_pd_out[PD_RED_BIT];
    nxt_power.green = colour_pd_out[PD_GREEN_BIT];
    nxt_power.blue = colour_pd_out[PD_BLUE_BIT];
    nxt_power.converter = power_reg_ff[PD_CONVERTER_BIT];
    nxt_power.clamp_dac = power_reg_ff[PD_CLAMP_DAC_BIT];
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      power_ff <= '0;
    end else begin
      power_ff <= nxt_power;
    end
  end

  // register reads, one cycle late, zero outside that cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        OFS_LINE_MODE: rdata_ff <= line_mode_ff;
        OFS_POWER: rdata_ff <= {3'h0, power_reg_ff};
        OFS_CLAMP_CFG: rdata_ff <= {6'h00, clamp_cfg_ff};
        OFS_STATUS: rdata_ff <= {2'h0, auto_active && correlated_sampling_enable, auto_active,
                                 front_ff.colour_sel, slot_code(slot_ff)};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign rdata = rdata_ff;
  assign power = power_ff;
  assign front = front_ff;
  // dac drives its pin only while powered
  assign clamp_dac_oe = !power_ff.clamp_dac;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence s_advance;
    auto_active && reset_sample_pin_pulse && !restart_wr;
  endsequence

  sequence s_power_write;
    hit(bus, OFS_POWER);
  endsequence

  sequence s_manual_active;
    single_line_mode && !auto_cycle_enable && manual_colour_select != SEL_RSVD;
  endsequence

  manual_select_a: assert property (
    s_manual_active |=> front.colour_sel == $past(manual_colour_select))
    else $error("manual colour select not applied");

  normal_mode_red_a: assert property (
    !single_line_mode |=> front.colour_sel == SEL_RED)
    else $error("colour select moved outside line mode");

  auto_advance_a: assert property (
    s_advance |=> slot_ff == slot_after($past(slot_ff)))
    else $error("auto cycle did not advance on pulse");

  cycle_wrap_a: assert property (
    (s_advance and slot_ff == gos_slot_blue) |=> slot_ff == gos_slot_red ##1 front.colour_sel == SEL_RED)
    else $error("auto cycle did not wrap from blue to red");

  cycle_restart_a: assert property (
    restart_wr |=> slot_ff == gos_slot_red)
    else $error("restart write did not return cycle to red");

  auto_ignored_a: assert property (
    (!single_line_mode && !restart_wr) |=> $stable(slot_ff))
    else $error("auto cycle moved outside line mode");

  clamp_override_a: assert property (
    auto_active |=> front.clamp_close == $past(clamp_override))
    else $error("clamp not following override while auto cycling");

  clamp_pin_a: assert property (
    !auto_active |=> front.clamp_close == $past(reset_sample_pin_sync))
    else $error("clamp not following pin");

  red_power_a: assert property (
    s_power_write |-> ##2 power.red == $past(bus.wdata[PD_RED_BIT], 2))
    else $error("red path power-down not applied");

  green_power_a: assert property (
    (s_power_write ##1 !single_line_mode) |-> ##1 power.green == $past(bus.wdata[PD_GREEN_BIT], 2))
    else $error("green path power-down not applied");

  blue_power_a: assert property (
    (s_power_write ##1 !single_line_mode) |-> ##1 power.blue == $past(bus.wdata[PD_BLUE_BIT], 2))
    else $error("blue path power-down not applied");

  converter_power_a: assert property (
    s_power_write |-> ##2 power.converter == $past(bus.wdata[PD_CONVERTER_BIT], 2))
    else $error("converter power-down not applied");

  dac_float_a: assert property (
    (s_power_write and bus.wdata[PD_CLAMP_DAC_BIT]) |-> ##2 (power.clamp_dac && !clamp_dac_oe))
    else $error("clamp dac still driving after power-down");

  line_mode_read_a: assert property (
    (bus.rd && bus.addr == OFS_LINE_MODE && !$past(hit(bus, OFS_LINE_MODE)))
      |=> rdata == $past(line_mode_ff))
    else $error("line mode read back wrong");

  sequence s_manual_reserved;
    single_line_mode && !auto_cycle_enable && manual_colour_select == SEL_RSVD;
  endsequence

  reserved_hold_a: assert property (
    s_manual_reserved |=> $stable(front.colour_sel))
    else $error("reserved manual code moved colour select");

  auto_select_a: assert property (
    auto_active |=> front.colour_sel == slot_code($past(slot_ff)))
    else $error("colour select not following auto cycle");

  manual_slot_hold_a: assert property (
    (single_line_mode && !auto_cycle_enable && !restart_wr) |=> $stable(slot_ff))
    else $error("auto cycle moved while manual select in use");

  cds_copy_a: assert property (
    !auto_active |=> front.cds_en == $past(correlated_sampling_enable))
    else $error("correlated sampling enable not applied");

  line_colour_down_a: assert property (
    single_line_mode |=> (power.green && power.blue))
    else $error("green or blue path powered in line mode");

  // red stays up in line mode: it carries the single input channel
  red_not_forced_a: assert property (
    (single_line_mode && !power_reg_ff[PD_RED_BIT]) |=> !power.red)
    else $error("red path powered down without its bit");

  converter_line_a: assert property (
    single_line_mode |=> power.converter == $past(power_reg_ff[PD_CONVERTER_BIT]))
    else $error("converter power-down changed by line mode");

  power_hold_a: assert property (
    !hit(bus, OFS_POWER) |=> $stable(power_reg_ff))
    else $error("power-down bits changed without a write");

  dac_drive_a: assert property (
    (s_power_write and !bus.wdata[PD_CLAMP_DAC_BIT]) |-> ##2 (!power.clamp_dac && clamp_dac_oe))
    else $error("clamp dac not driving while powered");

  status_auto_a: assert property (
    (bus.rd && bus.addr == OFS_STATUS) |=> rdata[ST_AUTO_BIT] == $past(auto_active))
    else $error("status auto bit wrong");

endmodule // gos_top

// ===== verification/gos_pin_model.sv
// Purpose: scanner timing controller model driving the reset-sample pin
// Assumes: pin idles low between pulses, pulse length chosen per request
// Notes: short and long pulses stand for prompt and slow controllers
`timescale 1ns/1ps
module gos_pin_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic fire,
  input wire logic [3:0] hold,
  output logic reset_sample_pin
);
  logic [3:0] left_ff;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      left_ff <= 4'h0;
    end else if (fire) begin
      left_ff <= hold;
    end else if (left_ff != 4'h0) begin
      left_ff <= left_ff - 4'h1;
    end
  end

  // driven low when idle, never floated: the pin has no pull
  assign reset_sample_pin = (left_ff != 4'h0);
endmodule // gos_pin_model

// ===== verification/gos_top_tb.sv
// Purpose: self-checking bench for colour select, auto-cycling and power-down
// Assumes: register port with one-cycle strobes, pin model as far side
// Notes: waits after writes cover the one-edge output lag
`timescale 1ns/1ps
module gos_top_tb;
  import gos_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  gos_bus_t bus = '0;
  logic [7:0] rdata;
  logic pin;
  gos_power_t power;
  gos_front_t front;
  logic clamp_dac_oe;
  logic fire = 1'b0;
  logic [3:0] hold = 4'h2;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 mclk = ~mclk;

  gos_top DUT (.mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata), .reset_sample_pin(pin),
    .power(power), .front(front), .clamp_dac_oe(clamp_dac_oe));

  gos_pin_model partner (.mclk(mclk), .nrst(nrst), .fire(fire), .hold(hold), .reset_sample_pin(pin));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard, run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus <= '0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic pulse(input logic [3:0] len);
    @(posedge mclk);
    fire <= 1'b1;
    hold <= len;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (len + 6) @(posedge mclk);
    #1;
  endtask

  task automatic sel(input logic [7:0] exp);
    chk({6'h0, front.colour_sel}, exp);
  endtask

  task automatic t_reset();
    chk({3'h0, power}, 8'h00);
    chk({7'h0, clamp_dac_oe}, 8'h01);
    sel(8'h00);
    rd(OFS_LINE_MODE, 8'h00);
    rd(OFS_POWER, 8'h00);
  endtask

  task automatic t_power();
    for (int i = 0; i < 5; i++) begin
      wr(OFS_POWER, 8'h01 << i);
      chk({3'h0, power}, 8'h01 << i);
      chk({7'h0, clamp_dac_oe}, {7'h0, i != 4});
      rd(OFS_POWER, 8'h01 << i);
    end
    wr(OFS_POWER, 8'h00);
  endtask

  // upper line-mode bits always written as zero
  task automatic t_manual();
    for (int c = 0; c < 3; c++) begin
      wr(OFS_LINE_MODE, 8'h01 | (c[7:0] << 2));
      sel(c[7:0]);
    end
    wr(OFS_LINE_MODE, 8'h0d);
    sel(8'h02);
    chk({3'h0, power}, 8'h06);
    wr(OFS_LINE_MODE, 8'h04);
    sel(8'h00);
    rd(OFS_LINE_MODE, 8'h04);
    wr(OFS_CLAMP_CFG, 8'h02);
    chk({7'h0, front.cds_en}, 8'h01);
    rd(OFS_STATUS, 8'h00);
  endtask

  task automatic t_auto();
    wr(OFS_CLAMP_CFG, 8'h00);
    chk({7'h0, front.cds_en}, 8'h00);
    wr(OFS_LINE_MODE, 8'h02);
    pulse(4'h3);
    sel(8'h00);
    rd(OFS_STATUS, 8'h00);
    wr(OFS_LINE_MODE, 8'h0b);
    sel(8'h00);
    pulse(4'h2);
    sel(8'h01);
    rd(OFS_STATUS, 8'h15);
    pulse(4'h9);
    sel(8'h02);
    pulse(4'h2);
    sel(8'h00);
    pulse(4'h2);
    sel(8'h01);
    wr(OFS_CYCLE_RESTART, 8'h5a);
    sel(8'h00);
    wr(OFS_CLAMP_CFG, 8'h01);
    chk({7'h0, front.clamp_close}, 8'h01);
    wr(OFS_CLAMP_CFG, 8'h00);
  endtask

  // long pulse, clamp looked at while the pin is still high
  task automatic t_clamp(input logic [7:0] mode, input logic [7:0] exp);
    wr(OFS_LINE_MODE, mode);
    @(posedge mclk);
    fire <= 1'b1;
    hold <= 4'hc;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (7) @(posedge mclk);
    #1;
    chk({7'h0, front.clamp_close}, exp);
    repeat (10) @(posedge mclk);
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_power();
    t_manual();
    t_auto();
    t_clamp(8'h01, 8'h01);
    t_clamp(8'h03, 8'h00);
    rd(6'h3f, 8'h00);
    close_out();
  end
endmodule // gos_top_tb
